// >>> core/vbi_params.svh
// Constants for the vertical-blanking caption and wide-screen inserter
// Overview of operation
// RULE_01 - Wide-screen signal on line 23, PAL only
// RULE_02 - Wide-screen payload is exactly 14 bits
// RULE_03 - Run-in then start code precede payload
// RULE_04 - Line 23 carries video after 42.5 us
// RULE_05 - Control 0x99 bit 7 gates wide-screen insertion
// RULE_06 - Control 0xA1 bit 7 blanks signaling portion
// RULE_07 - Software codes aspect ratio in bits 3..0
// RULE_08 - Software codes mode, colour, subtitle bits
// RULE_09 - Software codes sound and copy bits 11..13
// RULE_10 - Captions on line 21 odd, 284 even
// RULE_11 - Control 0x83 bits 6..5 enable captions
// RULE_12 - Caption line starts with 7-cycle run-in
// RULE_13 - Two blank bits, start bit, 16 data
// RULE_14 - Host bytes carry seven bits plus parity
// RULE_15 - Odd field bytes from 0x93 and 0x94
// RULE_16 - Even field bytes from 0x91 and 0x92
// RULE_17 - All caption timing generated internally
// RULE_18 - Pixel input replaced on caption lines
// RULE_19 - Single buffered, sent on next line
// RULE_20 - Host loads bytes a line early, each field
// RULE_21 - Host writes zeros when nothing to send
// RULE_22 - Host keeps control code pairs in one field
`ifndef VBI_PARAMS_SVH
`define VBI_PARAMS_SVH

// Register subaddresses and reset value
`define VBI_A_CC_MODE    8'h83
`define VBI_A_CCX_A      8'h91
`define VBI_A_CCX_B      8'h92
`define VBI_A_CCO_A      8'h93
`define VBI_A_CCO_B      8'h94
`define VBI_A_WSIG_HI    8'h99
`define VBI_A_WSIG_MID   8'h9A
`define VBI_A_WSIG_LO    8'h9B
`define VBI_A_WSIG_BLANK 8'hA1
`define VBI_REG_RST      8'h00

// Field positions
`define VBI_WSIG_EN_BIT  7
`define VBI_WSIG_BLK_BIT 7
`define VBI_CC_ODD_BIT   5
`define VBI_CC_EVEN_BIT  6
`define VBI_STAT_BIT     0

// Line numbers
`define VBI_WSIG_LINE    10'h017
`define VBI_CC_ODD_LINE  10'h015
`define VBI_CC_EVEN_LINE 10'h11C

// Wide-screen sequences, sent first bit on the left; element and quarter counts
`define VBI_WSIG_RUNIN   29'h1F1C71C7
`define VBI_WSIG_START   24'h1E3C1F
`define VBI_BIPH_ONE     6'h38
`define VBI_BIPH_ZERO    6'h07
`define VBI_WSIG_LAST    8'h88
`define VBI_CC_RUNIN_Q   8'h1C
`define VBI_CC_START_Q   8'h24
`define VBI_CC_DATA_Q    8'h28
`define VBI_CC_LAST      8'h67

// Output levels
`define VBI_LVL_BLANK    10'h0F0
`define VBI_LVL_MID      10'h1D8
`define VBI_LVL_HIGH     10'h2C0

// Times and derived cycle counts
`define VBI_CLK_MHZ      100
`define VBI_WSIG_ELEM_NS 200
`define VBI_CC_BIT_NS    1986
`define VBI_WSIG_POS_NS  11000
`define VBI_CC_POS_NS    10500
`define VBI_VIDEO_NS     42500
`define VBI_CYC_UP(ns)   ((((ns) * `VBI_CLK_MHZ) + 999) / 1000)
`define VBI_CYC_DN(ns)   (((ns) * `VBI_CLK_MHZ) / 1000)

`endif

// >>> core/vbi_pkg.sv
// Types shared by the inserter modules
`include "vbi_params.svh"
package vbi_pkg;
    typedef enum logic [1:0] {VBI_IDLE, VBI_PRE, VBI_SEND, VBI_POST}
        vbi_state_t;
    typedef enum logic {VBI_M_WSIG, VBI_M_CC} vbi_mode_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } vbi_div_t;

    typedef struct packed {
        vbi_state_t  state;
        vbi_mode_t   mode;
        logic [12:0] cnt;
        logic [7:0]  elt;
        logic [136:0] sh;
        logic [7:0]  cc_mode_ctrl;
        logic [7:0]  cc_extended_byte_a;
        logic [7:0]  cc_extended_byte_b;
        logic [7:0]  cc_odd_field_byte_a;
        logic [7:0]  cc_odd_field_byte_b;
        logic [7:0]  widescreen_ctrl_and_data_hi;
        logic [7:0]  widescreen_data_mid;
        logic [7:0]  widescreen_data_lo;
        logic [7:0]  wsig_blank_ctrl;
        logic [7:0]  rdata;
        logic        act;
        logic [9:0]  pix;
    } vbi_core_t;
endpackage : vbi_pkg

// >>> core/vbi_if.sv
// Rate request and tick between engine and divider
`timescale 1ns/1ns
interface vbi_if;
    logic [7:0] period;  // Cycles per tick
    logic       run;     // Divider runs while high
    logic       tick;    // One-cycle rate pulse
    modport eng (output period, output run, input tick);
    modport div (input period, input run, output tick);
endinterface : vbi_if

// >>> core/vbi_div.sv
// Rate divider giving one-cycle tick pulses
`timescale 1ns/1ns
module vbi_div (
    input wire logic core_clk,  // Pixel clock
    input wire logic nrst,      // Async reset, active low
    vbi_if.div       bus        // Period in, tick out
);
    vbi_pkg::vbi_div_t cur_ff;  // Registered state
    vbi_pkg::vbi_div_t nxt_div; // Next state

    ////////////////////////////////////////////////////////////////////
    // Count to period, restart whenever run drops
    always_comb begin
        nxt_div      = cur_ff;
        nxt_div.tick = 1'b0;
        if (!bus.run) begin
            nxt_div.cnt = 8'h00;
        end else if (cur_ff.cnt == 8'(bus.period - 8'h01)) begin
            nxt_div.cnt  = 8'h00;
            nxt_div.tick = 1'b1;
        end else begin
            nxt_div.cnt = 8'(cur_ff.cnt + 8'h01);
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_div;
        end
    end

    assign bus.tick = cur_ff.tick;
endmodule : vbi_div

// >>> core/vbi_inserter.sv
// Caption and wide-screen signal inserter for SD vertical blanking
`timescale 1ns/1ns
`include "vbi_params.svh"
module vbi_inserter #(
    parameter logic [12:0] WSIG_POS_CYC =
        13'(`VBI_CYC_UP(`VBI_WSIG_POS_NS)),
    parameter logic [12:0] CC_POS_CYC =
        13'(`VBI_CYC_UP(`VBI_CC_POS_NS)),
    parameter logic [12:0] VIDEO_CYC =
        13'(`VBI_CYC_UP(`VBI_VIDEO_NS)),
    parameter logic [7:0]  WSIG_ELEM_CYC =
        8'(`VBI_CYC_DN(`VBI_WSIG_ELEM_NS)),
    parameter logic [7:0]  CC_QTR_CYC =
        8'(`VBI_CYC_DN(`VBI_CC_BIT_NS) / 4)
) (
    input  wire logic       core_clk,   // Pixel clock
    input  wire logic       nrst,       // Async reset, active low
    input  wire logic       reg_wr,     // Register write strobe
    input  wire logic       reg_rd,     // Register read strobe
    input  wire logic [7:0] reg_addr,   // Register subaddress
    input  wire logic [7:0] reg_wdata,  // Write data
    output logic      [7:0] reg_rdata,  // Read data, next cycle
    input  wire logic       pal_mode,   // Encoder set for PAL
    input  wire logic       line_start, // Falling sync edge pulse
    input  wire logic [9:0] line_num,   // Frame line number
    input  wire logic       field_odd,  // Odd field flag
    input  wire logic [9:0] pix_in,     // Incoming pixel
    output logic      [9:0] pix_out,    // Outgoing pixel
    output logic            vbi_active  // Line under override
);
    vbi_pkg::vbi_core_t cur_ff;   // Registered state
    vbi_pkg::vbi_core_t nxt_core; // Next state
    vbi_if              rate ();  // Link to divider
    logic [13:0]        wsig_data;  // Assembled payload
    logic [83:0]        wsig_biph;  // Biphase payload elements
    logic               wsig_line;  // This line takes the signal
    logic               cc_odd;     // Odd field caption line
    logic               cc_even;    // Even field caption line

    ////////////////////////////////////////////////////////////////////
    // Payload from the mid and low signaling registers
    assign wsig_data = {cur_ff.widescreen_data_mid[5:0],  // RULE_02
                        cur_ff.widescreen_data_lo};

    // Each payload bit becomes six elements, bit 0 sent first
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi++) begin : g_biph
            assign wsig_biph[83 - 6 * gi -: 6] =
                wsig_data[gi] ? `VBI_BIPH_ONE : `VBI_BIPH_ZERO;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Line qualification from the timing generator
    assign wsig_line = pal_mode                                // RULE_01
        && (line_num == `VBI_WSIG_LINE)
        && cur_ff.widescreen_ctrl_and_data_hi[`VBI_WSIG_EN_BIT]; // RULE_05
    // Captions follow field parity
    assign cc_odd  = field_odd && (line_num == `VBI_CC_ODD_LINE) // RULE_10
        && cur_ff.cc_mode_ctrl[`VBI_CC_ODD_BIT];               // RULE_11
    assign cc_even = !field_odd && (line_num == `VBI_CC_EVEN_LINE)
        && cur_ff.cc_mode_ctrl[`VBI_CC_EVEN_BIT];              // RULE_11

    ////////////////////////////////////////////////////////////////////
    // Divider rate follows the active mode
    assign rate.period = (cur_ff.mode == vbi_pkg::VBI_M_WSIG) ?
        WSIG_ELEM_CYC : CC_QTR_CYC;
    // Divider idles outside the waveform
    assign rate.run    = (cur_ff.state == vbi_pkg::VBI_SEND);

    vbi_div u_div (
        .core_clk (core_clk),
        .nrst     (nrst),
        .bus      (rate.div)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state: registers, line sequencer, pixel path
    always_comb begin
        nxt_core = cur_ff;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `VBI_A_CC_MODE:    nxt_core.cc_mode_ctrl = reg_wdata;
                `VBI_A_CCX_A:      nxt_core.cc_extended_byte_a = reg_wdata;
                `VBI_A_CCX_B:      nxt_core.cc_extended_byte_b = reg_wdata;
                `VBI_A_CCO_A:      nxt_core.cc_odd_field_byte_a = reg_wdata;
                `VBI_A_CCO_B:      nxt_core.cc_odd_field_byte_b = reg_wdata;
                `VBI_A_WSIG_HI:
                    nxt_core.widescreen_ctrl_and_data_hi = reg_wdata;
                `VBI_A_WSIG_MID:   nxt_core.widescreen_data_mid = reg_wdata;
                `VBI_A_WSIG_LO:    nxt_core.widescreen_data_lo = reg_wdata;
                `VBI_A_WSIG_BLANK: nxt_core.wsig_blank_ctrl = reg_wdata;
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads, unmapped reads return zero
        if (reg_rd) begin
            unique case (reg_addr)
                `VBI_A_CC_MODE:    nxt_core.rdata = cur_ff.cc_mode_ctrl;
                `VBI_A_CCX_A:      nxt_core.rdata = cur_ff.cc_extended_byte_a;
                `VBI_A_CCX_B:      nxt_core.rdata = cur_ff.cc_extended_byte_b;
                `VBI_A_CCO_A:
                    nxt_core.rdata = cur_ff.cc_odd_field_byte_a;
                `VBI_A_CCO_B:
                    nxt_core.rdata = cur_ff.cc_odd_field_byte_b;
                `VBI_A_WSIG_HI:
                    nxt_core.rdata = cur_ff.widescreen_ctrl_and_data_hi;
                `VBI_A_WSIG_MID:
                    nxt_core.rdata = cur_ff.widescreen_data_mid;
                `VBI_A_WSIG_LO:
                    nxt_core.rdata = cur_ff.widescreen_data_lo;
                `VBI_A_WSIG_BLANK: begin
                    // Low bit shows the live override state
                    nxt_core.rdata = cur_ff.wsig_blank_ctrl;
                    nxt_core.rdata[`VBI_STAT_BIT] = cur_ff.act;
                end
                default: nxt_core.rdata = `VBI_REG_RST;
            endcase
        end

        // Line position counter, saturates on long lines
        if (cur_ff.cnt != '1) begin
            nxt_core.cnt = 13'(cur_ff.cnt + 13'h0001);          // RULE_17
        end

        if (line_start) begin
            // New line: decide the override and load one shot
            nxt_core.cnt = '0;
            nxt_core.elt = '0;
            if (wsig_line) begin
                nxt_core.state = vbi_pkg::VBI_PRE;
                nxt_core.mode  = vbi_pkg::VBI_M_WSIG;
                nxt_core.sh    = {`VBI_WSIG_RUNIN,              // RULE_03
                                  `VBI_WSIG_START, wsig_biph};
            end else if (cc_odd) begin
                // Live bytes go out now, no second buffer stage
                nxt_core.state = vbi_pkg::VBI_PRE;
                nxt_core.mode  = vbi_pkg::VBI_M_CC;
                nxt_core.sh    = {118'h0,                       // RULE_19
                                  cur_ff.cc_odd_field_byte_b,   // RULE_15
                                  cur_ff.cc_odd_field_byte_a,
                                  3'h4};                        // RULE_13
            end else if (cc_even) begin
                nxt_core.state = vbi_pkg::VBI_PRE;
                nxt_core.mode  = vbi_pkg::VBI_M_CC;
                nxt_core.sh    = {118'h0,                       // RULE_19
                                  cur_ff.cc_extended_byte_b,    // RULE_16
                                  cur_ff.cc_extended_byte_a,
                                  3'h4};                        // RULE_13
            end else begin
                nxt_core.state = vbi_pkg::VBI_IDLE;
            end
        end else begin
            unique case (cur_ff.state)
                vbi_pkg::VBI_IDLE: begin
                    // Pixels pass through untouched
                end
                vbi_pkg::VBI_PRE: begin
                    // Hold blank until the waveform position
                    if (cur_ff.mode == vbi_pkg::VBI_M_WSIG) begin
                        if (cur_ff.cnt == 13'(WSIG_POS_CYC - 13'h0001)) begin
                            nxt_core.state = vbi_pkg::VBI_SEND;
                        end
                    end else if (cur_ff.cnt ==
                                 13'(CC_POS_CYC - 13'h0001)) begin
                        nxt_core.state = vbi_pkg::VBI_SEND;    // RULE_17
                    end
                end
                vbi_pkg::VBI_SEND: begin
                    if (rate.tick) begin
                        nxt_core.elt = 8'(cur_ff.elt + 8'h01);
                        if (cur_ff.mode == vbi_pkg::VBI_M_WSIG) begin
                            // One element per tick, first on the left
                            nxt_core.sh = {cur_ff.sh[135:0], 1'b0};
                            if (cur_ff.elt == `VBI_WSIG_LAST) begin
                                nxt_core.state = vbi_pkg::VBI_POST; // RULE_02
                            end
                        end else begin
                            // Quarter ticks; bits move on at a bit end
                            if ((cur_ff.elt >= `VBI_CC_RUNIN_Q)
                                && (cur_ff.elt[1:0] == 2'h3)) begin
                                nxt_core.sh = {1'b0, cur_ff.sh[136:1]};
                            end
                            if (cur_ff.elt == `VBI_CC_LAST) begin
                                nxt_core.state = vbi_pkg::VBI_POST;
                            end
                        end
                    end
                end
                vbi_pkg::VBI_POST: begin
                    // Signaling line returns to video late in the line
                    if ((cur_ff.mode == vbi_pkg::VBI_M_WSIG)
                        && (cur_ff.cnt >= 13'(VIDEO_CYC - 13'h0001))) begin
                        nxt_core.state = vbi_pkg::VBI_IDLE;     // RULE_04
                    end
                end
            endcase
        end

        // Status flag from the next state
        nxt_core.act = (nxt_core.state != vbi_pkg::VBI_IDLE);

        // Pixel path, derived from the next state so both line up
        unique case (nxt_core.state)
            vbi_pkg::VBI_IDLE: nxt_core.pix = pix_in;
            vbi_pkg::VBI_SEND: begin
                if (nxt_core.mode == vbi_pkg::VBI_M_WSIG) begin
                    if (cur_ff.wsig_blank_ctrl[`VBI_WSIG_BLK_BIT]) begin
                        nxt_core.pix = `VBI_LVL_BLANK;           // RULE_06
                    end else begin
                        nxt_core.pix = nxt_core.sh[136] ?
                            `VBI_LVL_HIGH : `VBI_LVL_BLANK;
                    end
                end else if (nxt_core.elt < `VBI_CC_RUNIN_Q) begin
                    // Four-step sine, one cycle per caption bit
                    unique case (nxt_core.elt[1:0])
                        2'h0: nxt_core.pix = `VBI_LVL_MID;       // RULE_12
                        2'h1: nxt_core.pix = `VBI_LVL_HIGH;
                        2'h2: nxt_core.pix = `VBI_LVL_MID;
                        2'h3: nxt_core.pix = `VBI_LVL_BLANK;
                    endcase
                end else begin
                    nxt_core.pix = nxt_core.sh[0] ?
                        `VBI_LVL_HIGH : `VBI_LVL_BLANK;
                end
            end
            default: nxt_core.pix = `VBI_LVL_BLANK;             // RULE_18
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register, all control at zero after reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_core;
        end
    end

    // Outputs straight from flops
    assign reg_rdata  = cur_ff.rdata;
    assign pix_out    = cur_ff.pix;
    assign vbi_active = cur_ff.act;

    ////////////////////////////////////////////////////////////////////
    // Checks on the inserted waveform
    // Checks sample on the pixel clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Start events for the checks below
    sequence wsig_go;  // Signal line override began
        $rose(cur_ff.act) && (cur_ff.mode == vbi_pkg::VBI_M_WSIG);
    endsequence
    sequence cc_go;    // Caption line override began
        $rose(cur_ff.act) && (cur_ff.mode == vbi_pkg::VBI_M_CC);
    endsequence

    // Signal line only in PAL
    AST_WSIG_PAL_ONLY: assert property ( // RULE_01
        wsig_go |-> $past(pal_mode) && ($past(line_num) == `VBI_WSIG_LINE))
        else $error("signal line started outside PAL line 23");

    // Signal enable gates it
    AST_WSIG_GATE: assert property ( // RULE_05
        wsig_go |->
            $past(cur_ff.widescreen_ctrl_and_data_hi[`VBI_WSIG_EN_BIT]))
        else $error("signal line started while disabled");

    // Full element count sent
    AST_WSIG_LENGTH: assert property ( // RULE_03
        $fell(cur_ff.state == vbi_pkg::VBI_SEND)
        && (cur_ff.mode == vbi_pkg::VBI_M_WSIG) && !$past(line_start)
        |-> $past(cur_ff.elt) == `VBI_WSIG_LAST)
        else $error("signal element count wrong");

    // Blank bit mutes waveform
    AST_WSIG_BLANK: assert property ( // RULE_06
        (cur_ff.state == vbi_pkg::VBI_SEND)
        && (cur_ff.mode == vbi_pkg::VBI_M_WSIG)
        && $past(cur_ff.wsig_blank_ctrl[`VBI_WSIG_BLK_BIT])
        |-> cur_ff.pix == `VBI_LVL_BLANK)
        else $error("signal portion not blanked");

    // Video passes; reset pixel skipped
    AST_VIDEO_PASS: assert property ( // RULE_04
        (cur_ff.state == vbi_pkg::VBI_IDLE) && $past(nrst)
        |-> cur_ff.pix == $past(pix_in))
        else $error("video not passed through");

    // Caption on its own line
    AST_CC_LINE: assert property ( // RULE_10
        cc_go |-> ($past(field_odd) && ($past(line_num) == `VBI_CC_ODD_LINE))
            || (!$past(field_odd)
                && ($past(line_num) == `VBI_CC_EVEN_LINE)))
        else $error("caption on wrong line");

    // Field enable honoured
    AST_CC_ENABLE: assert property ( // RULE_11
        cc_go |-> ($past(field_odd) ?
            $past(cur_ff.cc_mode_ctrl[`VBI_CC_ODD_BIT]) :
            $past(cur_ff.cc_mode_ctrl[`VBI_CC_EVEN_BIT])))
        else $error("caption sent while disabled");

    // Run-in reaches its peak
    AST_CC_RUNIN_PEAK: assert property ( // RULE_12
        (cur_ff.state == vbi_pkg::VBI_SEND)
        && (cur_ff.mode == vbi_pkg::VBI_M_CC)
        && (cur_ff.elt < `VBI_CC_RUNIN_Q) && (cur_ff.elt[1:0] == 2'h1)
        |-> cur_ff.pix == `VBI_LVL_HIGH)
        else $error("run-in peak missing");

    // Gap then start bit
    AST_CC_FRAME: assert property ( // RULE_13
        (cur_ff.state == vbi_pkg::VBI_SEND)
        && (cur_ff.mode == vbi_pkg::VBI_M_CC)
        && (cur_ff.elt >= `VBI_CC_RUNIN_Q) && (cur_ff.elt < `VBI_CC_DATA_Q)
        |-> cur_ff.pix == ((cur_ff.elt < `VBI_CC_START_Q) ?
            `VBI_LVL_BLANK : `VBI_LVL_HIGH))
        else $error("caption gap or start bit wrong");

    // No video leaks through
    AST_CC_OVERRIDE: assert property ( // RULE_18
        cur_ff.act && (cur_ff.mode == vbi_pkg::VBI_M_CC)
        && (cur_ff.state != vbi_pkg::VBI_SEND)
        |-> cur_ff.pix == `VBI_LVL_BLANK)
        else $error("pixel input leaked on caption line");

    // Main scenarios
    CVR_WSIG_SEND: cover property (
        (cur_ff.state == vbi_pkg::VBI_POST)
        && (cur_ff.mode == vbi_pkg::VBI_M_WSIG));

    CVR_CC_ODD: cover property (cc_go ##0 $past(field_odd));

    CVR_CC_EVEN: cover property (cc_go ##0 !$past(field_odd));

    CVR_WSIG_BLANKED: cover property (
        (cur_ff.state == vbi_pkg::VBI_SEND)
        && cur_ff.wsig_blank_ctrl[`VBI_WSIG_BLK_BIT]);
endmodule : vbi_inserter

// >>> tb/vbi_host.sv
// Host model that loads the inserter payload registers
`timescale 1ns/1ns
module vbi_host (
    input  wire logic       core_clk,  // Pixel clock
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    output logic      [7:0] reg_addr,  // Subaddress
    output logic      [7:0] reg_wdata, // Write data
    input  wire logic [7:0] reg_rdata  // Read data
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge core_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask : wr
    // Read strobe; data is taken one cycle after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge core_clk) #1;
        {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask : rd
    // Odd parity into bit 7 of a caption byte
    function automatic logic [7:0] par(input logic [6:0] c);
        return {~^c, c};
    endfunction : par
    // Both bytes of one field loaded together, a line early
    task automatic cc(input logic odd, input logic [6:0] a, b);
        wr(odd ? 8'h93 : 8'h91, par(a));
        wr(odd ? 8'h94 : 8'h92, par(b));
    endtask : cc
    // Fourteen payload bits split over two registers
    task automatic wide_screen_signal(input logic [13:0] p);
        wr(8'h9A, {2'b00, p[13:8]});
        wr(8'h9B, p[7:0]);
    endtask : wide_screen_signal
endmodule : vbi_host

// >>> tb/tb.sv
// Self-checking bench for the caption and wide-screen inserter
`timescale 1ns/1ns
`include "vbi_params.svh"
module tb;
    logic core_clk, nrst, reg_wr, reg_rd, pal_mode, line_start, field_odd;
    logic       vbi_active; // Override flag
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
    logic [9:0] line_num, pix_in, pix_out, pin_q;
    logic [9:0] q[$];       // Expected element levels
    logic [13:0] pl;        // Wide-screen payload
    logic [6:0] ca, cb;     // Caption characters
    int         n_errors, compares, i, k;
    logic [7:0] ad[9] = '{8'h83, 8'h91, 8'h92, 8'h93, 8'h94, 8'h99,
                          8'h9A, 8'h9B, 8'hA1};
    logic [3:0] ar[8] = '{4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7};
    vbi_inserter #(.WSIG_POS_CYC(13'h014), .CC_POS_CYC(13'h014),
        .VIDEO_CYC(13'h2BC), .WSIG_ELEM_CYC(8'h04), .CC_QTR_CYC(8'h04))
        u_vbi_inserter (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pal_mode(pal_mode), .line_start(line_start),
        .line_num(line_num), .field_odd(field_odd), .pix_in(pix_in),
        .pix_out(pix_out), .vbi_active(vbi_active));
    vbi_host u_vbi_host (.core_clk(core_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    ////////////////////////////////////////////////////////////////////////
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    // Random video; pin_q is the pixel the edge saw
    always @(posedge core_clk) pix_in <= #1 10'($urandom);
    always @(posedge core_clk) pin_q <= pix_in;
    task automatic chk_reg(input logic [7:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_reg
    task automatic chk_pix(input logic [9:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_pix
    function automatic logic [9:0] lv(input logic b);
        return b ? `VBI_LVL_HIGH : `VBI_LVL_BLANK;
    endfunction : lv
    // Caption model: sine run-in, two blank bits, start bit, 16 data
    task automatic cap(input logic [7:0] a, b);
        q = {};
        repeat (7) q = {q, `VBI_LVL_MID, `VBI_LVL_HIGH, `VBI_LVL_MID,
                        `VBI_LVL_BLANK};
        for (i = 0; i < 19; i++) repeat (4)
            q.push_back(lv(i == 2 || i > 2 && (i < 11 ? a[i-3] : b[i-11])));
    endtask : cap
    // Wide-screen model: run-in, start code, biphase payload LSB first
    task automatic ws(input logic [13:0] p, input logic blk);
        logic [52:0] h;
        h = {`VBI_WSIG_RUNIN, `VBI_WSIG_START};
        q = {};
        for (i = 52; i >= 0; i--) q.push_back(lv(h[i] & !blk));
        for (i = 0; i < 84; i++)
            q.push_back(lv((i % 6 < 3 ? p[i/6] : !p[i/6]) & !blk));
    endtask : ws
    // One line; quarters sampled mid-element, edges of elements skipped
    task automatic run(input logic [9:0] ln, input logic odd, ov,
                       input int v);
        int c;
        int n;
        n = q.size();
        @(posedge core_clk) #1;
        {line_start, line_num, field_odd} = {1'b1, ln, odd};
        @(posedge core_clk) #1;
        line_start = 1'b0;
        for (c = 1; c <= 740; c++) begin
            @(posedge core_clk) #1;
            if (c == 10) chk_pix(10'(vbi_active), 10'(ov), "active");
            if (!ov || v > 0 && c > v + 2)
                chk_pix(pix_out, pin_q, "pass");
            else if (c > 2 && c < 19 || c > 22 + 4 * n && (v == 0 || c < v))
                chk_pix(pix_out, `VBI_LVL_BLANK, "blank");
            else if (c >= 22 && (c - 22) % 4 == 0 && (c - 22) / 4 < n)
                chk_pix(pix_out, q[(c-22)/4], "wave");
        end
    endtask : run
    task final_report;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        #900000 n_errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, pal_mode, line_start, field_odd, line_num, pix_in} = '0;
        void'($urandom(32'h046D));
        repeat (6) @(posedge core_clk);
        #1 nrst = 1'b1;
        // Reset value and readback of each register, then a hole
        foreach (ad[j]) begin
            u_vbi_host.rd(ad[j], d);
            chk_reg(d, 8'h00, "reset");
            r = 8'($urandom) & 8'hFE;
            u_vbi_host.wr(ad[j], r);
            u_vbi_host.rd(ad[j], d);
            chk_reg(d, r, "readback");
        end
        u_vbi_host.wr(8'h50, 8'hFF);
        u_vbi_host.rd(8'h50, d);
        chk_reg(d, 8'h00, "unmapped");
        u_vbi_host.wr(8'hA1, 8'h00);
        // Odd, even, then odd with zero bytes; other field's enable must not insert
        for (k = 0; k < 3; k++) begin
            {ca, cb} = 14'($urandom);
            if (k == 2) {ca, cb} = '0;
            u_vbi_host.wr(8'h83, k == 1 ? 8'h40 : 8'h20);
            if (k < 2) u_vbi_host.cc(k != 1, ca, cb);
            else u_vbi_host.cc(1'b1, 7'h00, 7'h00);
            cap({~^ca, ca}, {~^cb, cb});
            run(k == 1 ? 10'h11C : 10'h015, k != 1, 1'b1, 0);
            u_vbi_host.wr(8'h83, k == 1 ? 8'h20 : 8'h40);
            run(k == 1 ? 10'h11C : 10'h015, k != 1, 1'b0, 0);
        end
        // Payload with a table aspect code, reserved bits kept at zero
        pl = 14'($urandom) & 14'h3B70 | 14'(ar[$urandom % 8]);
        u_vbi_host.wide_screen_signal(pl);
        u_vbi_host.wr(8'h99, 8'h80);
        pal_mode = 1'b1;
        ws(pl, 1'b0);
        run(10'h017, 1'b1, 1'b1, 700);
        u_vbi_host.wr(8'hA1, 8'h80);
        ws(pl, 1'b1);
        run(10'h017, 1'b1, 1'b1, 700);
        pal_mode = 1'b0;
        run(10'h017, 1'b1, 1'b0, 700);
        u_vbi_host.wr(8'h99, 8'h00);
        pal_mode = 1'b1;
        run(10'h017, 1'b1, 1'b0, 700);
        final_report();
    end
endmodule : tb
